// ==== hdl/plt_defines.svh ====
// Offsets, field positions, reset values and timing figures of the timer bank.
// Included by the timer-bank design files; definitions only.
`ifndef PLT_DEFINES_SVH
`define PLT_DEFINES_SVH

// AXI4-Lite register byte offsets
`define PLT_OFF_ACCU 8'h00
`define PLT_OFF_OP 8'h04
`define PLT_OFF_SEL 8'h08
`define PLT_OFF_SCAN 8'h0C
`define PLT_OFF_BIN 8'h10
`define PLT_OFF_BCD 8'h14
`define PLT_ADDR_W 8

// Operation register fields
`define PLT_OP_IDX_LSB 0
`define PLT_OP_CODE_LSB 8
`define PLT_OP_CODE_W 3
`define PLT_OP_RLO_BIT 16

// Time word fields
`define PLT_TW_BCD_LSB 0
`define PLT_TW_BCD_W 12
`define PLT_TW_BASE_LSB 12
`define PLT_TW_BASE_W 2
`define PLT_CNT_W 10

// Scan register bits
`define PLT_SCAN_OUT_BIT 0
`define PLT_SCAN_RUN_BIT 1
`define PLT_SCAN_DONE_BIT 2

// Reset values
`define PLT_RST_WORD 32'h0000_0000
`define PLT_RST_CNT 10'h000

// Bus responses
`define PLT_RESP_OKAY 2'h0
`define PLT_RESP_SLVERR 2'h2

// Timing: clock period and smallest time base, both in ns
`define PLT_CLK_PERIOD_NS 50
`define PLT_BASE0_PERIOD_NS 10000000
`define PLT_DECADE 4'h9

`endif

// ==== hdl/plt_pkg.sv ====
// Types shared by the timer-bank design files.
// Assumes nothing of its surroundings.
package plt_pkg;

   // Operation codes; a timer's mode takes the code on a starting edge, a clearing op or any off-delay op
   typedef enum logic [2:0] {
      plt_pulse_mode = 3'b000,
      plt_extended_pulse_mode = 3'b001,
      plt_on_delay_mode = 3'b010,
      plt_stored_on_delay_mode = 3'b011,
      plt_off_delay_mode = 3'b100,
      plt_reset_op = 3'b101,
      plt_no_op_a = 3'b110,
      plt_no_op_b = 3'b111
   } plt_op_type;

endpackage : plt_pkg

// ==== hdl/plt_prescaler.sv ====
// Free-running time-base prescaler: one-cycle ticks for 0.01 s, 0.1 s,
// 1 s and 10 s. Assumes a synchronous active-high reset on mclk.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module plt_prescaler #(
   parameter int TICK_CYCLES = `PLT_BASE0_PERIOD_NS / `PLT_CLK_PERIOD_NS
) (
   input wire logic mclk,
   input wire logic sys_rst,
   output logic [3:0] tick_o
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES - 1);

   logic [PW-1:0] pre_r;
   logic [3:0] dec_r [3];
   logic [3:0] hit;

   always_comb begin
      hit[0] = (pre_r == LAST);
      hit[1] = hit[0] && (dec_r[0] == `PLT_DECADE);
      hit[2] = hit[1] && (dec_r[1] == `PLT_DECADE);
      hit[3] = hit[2] && (dec_r[2] == `PLT_DECADE);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || hit[0]) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + PW'(1);
      end
   end

   // Decade stages keep the four bases phase-locked to each other
   always_ff @(posedge mclk) begin
      for (int k = 0; k < 3; k++) begin
         if (sys_rst || hit[k+1]) begin
            dec_r[k] <= 4'h0;
         end else if (hit[k]) begin
            dec_r[k] <= dec_r[k] + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tick_o <= 4'h0;
      end else begin
         tick_o <= hit;
      end
   end

endmodule : plt_prescaler
`default_nettype wire

// ==== hdl/plt_time_codec.sv ====
// Three-digit BCD to binary and binary to BCD conversion, combinational.
// Assumes binary values stay below 1000.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module plt_time_codec (
   input wire logic [`PLT_TW_BCD_W-1:0] bcd_in,
   input wire logic [`PLT_CNT_W-1:0] bin_in,
   output logic [`PLT_CNT_W-1:0] bin_out,
   output logic [`PLT_TW_BCD_W-1:0] bcd_out
);
   function automatic logic [`PLT_CNT_W-1:0] bcd_to_bin(
      input logic [`PLT_TW_BCD_W-1:0] d);
      logic [`PLT_CNT_W-1:0] h, t, u;
      h = `PLT_CNT_W'(d[11:8]);
      t = `PLT_CNT_W'(d[7:4]);
      u = `PLT_CNT_W'(d[3:0]);
      return `PLT_CNT_W'(h * 10'd100 + t * 10'd10 + u);
   endfunction : bcd_to_bin

   // Shift-and-add-3; values over 999 are not representable
   function automatic logic [`PLT_TW_BCD_W-1:0] bin_to_bcd(
      input logic [`PLT_CNT_W-1:0] b);
      logic [`PLT_TW_BCD_W-1:0] acc;
      acc = '0;
      for (int i = `PLT_CNT_W - 1; i >= 0; i--) begin
         for (int j = 0; j < 3; j++) begin
            if (acc[j*4 +: 4] > 4'h4) begin
               acc[j*4 +: 4] = acc[j*4 +: 4] + 4'h3;
            end
         end
         acc = {acc[`PLT_TW_BCD_W-2:0], b[i]};
      end
      return acc;
   endfunction : bin_to_bcd

   always_comb begin
      bin_out = bcd_to_bin(bcd_in);
      bcd_out = bin_to_bcd(bin_in);
   end

endmodule : plt_time_codec
`default_nettype wire

// ==== hdl/plt_timer_unit.sv ====
// Bank of controller timers behind an AXI4-Lite slave.
// Assumes one master, synchronous inputs on mclk, synchronous reset.
//
// Notes on behaviour
// - Every start operation takes the accumulator word as the time value.
// - Base code 0..3 means 0.01 s, 0.1 s, 1 s, 10 s per count.
// - Count is BCD; the two top bits of the time word are ignored.
// - Elapsed time lies within one base unit below the programmed time.
// - Pulse, extended, on-delay and stored modes start on a rising logic bit.
// - Pulse and on-delay modes clear the timer while the logic bit is 0.
// - Extended, stored and reset leave the timer alone on a 0 logic bit.
// - Pulse and extended pulse output reads 1 while counting.
// - Stored on-delay output sets on expiry, holds until a reset operation, a new starting edge or an op that clears the timer.
// - Off-delay mode starts on a falling logic bit.
// - Off-delay holds the loaded value while the logic bit is 1.
// - Off-delay output reads 1 while logic bit is 1 or timer counts.
// - Reset operation forces the initial value while the logic bit is 1.
// - Output reads 0 while held in reset or never started, except off-delay, which reads 1 while its logic bit is 1.
// - Coded read gives BCD time and base; plain read gives binary.
// - A started timer counts down one per base tick until zero.
// - A starting edge while running reloads and restarts the timer.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module plt_timer_unit #(
   parameter int N_TIMERS = 16,
   parameter int TICK_CYCLES = `PLT_BASE0_PERIOD_NS / `PLT_CLK_PERIOD_NS
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`PLT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PLT_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int IDX_W = (N_TIMERS > 1) ? $clog2(N_TIMERS) : 1;
   localparam int CW = `PLT_CNT_W;

   // Bus-side state
   logic [`PLT_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_have_r;
   logic w_have_r;
   logic wr_go;
   logic [31:0] accu_r;
   logic [31:0] op_word_r;
   logic [31:0] sel_word_r;
   logic [31:0] rd_nxt;
   logic rd_err_nxt;

   // Operation decode
   logic op_go;
   logic [31:0] op_word_nxt;
   logic [IDX_W-1:0] op_idx;
   plt_pkg::plt_op_type op_code;
   logic op_rlo;

   // Timer state, one entry per timer
   logic [CW-1:0] cnt_r [N_TIMERS];
   logic [CW-1:0] init_r [N_TIMERS];
   logic [1:0] base_r [N_TIMERS];
   plt_pkg::plt_op_type mode_r [N_TIMERS];
   logic run_r [N_TIMERS];
   logic done_r [N_TIMERS];
   logic rlo_r [N_TIMERS];
   logic held_r [N_TIMERS];

   logic [3:0] tick_w;
   logic [CW-1:0] load_bin;
   logic [1:0] load_base;
   logic [IDX_W-1:0] sel_idx;
   logic [`PLT_TW_BCD_W-1:0] sel_bcd;

   // Byte-lane merge used by every writable register
   function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_strb

   // Scanned output of one timer from its stored state
   function automatic logic scan_of(input plt_pkg::plt_op_type mode,
                                    input logic run,
                                    input logic done,
                                    input logic logic_result_bit,
                                    input logic held);
      logic q;
      q = 1'b0;
      case (mode)
         plt_pkg::plt_pulse_mode,
         plt_pkg::plt_extended_pulse_mode: q = run;
         plt_pkg::plt_on_delay_mode: q = done && logic_result_bit;
         plt_pkg::plt_stored_on_delay_mode: q = done;
         plt_pkg::plt_off_delay_mode: q = logic_result_bit || run;
         default: q = 1'b0;
      endcase
      return q && !held;
   endfunction : scan_of

   plt_prescaler #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_prescaler (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick_o(tick_w)
   );

   // low twelve bits are the BCD count
   plt_time_codec u_codec (
      .bcd_in(accu_r[`PLT_TW_BCD_LSB +: `PLT_TW_BCD_W]),
      .bin_in(cnt_r[sel_idx]),
      .bin_out(load_bin),
      .bcd_out(sel_bcd)
   );

   // bits 14 and 15 never reach the timer
   assign load_base = accu_r[`PLT_TW_BASE_LSB +: `PLT_TW_BASE_W];
   assign sel_idx = sel_word_r[IDX_W-1:0];

   // Write channel: address and data taken in either order
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         aw_have_r <= 1'b0;
         awaddr_r <= '0;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_have_r &&
            !s_axi_bvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_wready <= 1'b0;
         w_have_r <= 1'b0;
         wdata_r <= `PLT_RST_WORD;
         wstrb_r <= 4'h0;
      end else begin
         s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_have_r &&
            !s_axi_bvalid;
         if (s_axi_wready && s_axi_wvalid) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PLT_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (awaddr_r)
            `PLT_OFF_ACCU, `PLT_OFF_OP, `PLT_OFF_SEL,
            `PLT_OFF_SCAN, `PLT_OFF_BIN, `PLT_OFF_BCD: begin
               s_axi_bresp <= `PLT_RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= `PLT_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // accumulator written by the sequencer before each start
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         accu_r <= `PLT_RST_WORD;
         sel_word_r <= `PLT_RST_WORD;
         op_word_r <= `PLT_RST_WORD;
      end else if (wr_go) begin
         if (awaddr_r == `PLT_OFF_ACCU) begin
            accu_r <= merge_strb(accu_r, wdata_r, wstrb_r);
         end
         if (awaddr_r == `PLT_OFF_SEL) begin
            sel_word_r <= merge_strb(sel_word_r, wdata_r, wstrb_r);
         end
         if (awaddr_r == `PLT_OFF_OP) begin
            op_word_r <= op_word_nxt;
         end
      end
   end

   // An operation executes in the cycle its register write completes
   always_comb begin
      op_word_nxt = merge_strb(op_word_r, wdata_r, wstrb_r);
      op_go = wr_go && (awaddr_r == `PLT_OFF_OP);
      op_idx = op_word_nxt[`PLT_OP_IDX_LSB +: IDX_W];
      op_code = plt_pkg::plt_op_type'(
         op_word_nxt[`PLT_OP_CODE_LSB +: `PLT_OP_CODE_W]);
      op_rlo = op_word_nxt[`PLT_OP_RLO_BIT];
   end

   // Timer bank; an operation on a timer overrides its tick that cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < N_TIMERS; i++) begin
            cnt_r[i] <= `PLT_RST_CNT;
            init_r[i] <= `PLT_RST_CNT;
            base_r[i] <= 2'h0;
            mode_r[i] <= plt_pkg::plt_pulse_mode;
            run_r[i] <= 1'b0;
            done_r[i] <= 1'b0;
            rlo_r[i] <= 1'b0;
            held_r[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < N_TIMERS; i++) begin
            // tick chosen by base code; free phase gives the tolerance
            if (run_r[i] && tick_w[base_r[i]]) begin
               if (cnt_r[i] <= CW'(1)) begin
                  cnt_r[i] <= `PLT_RST_CNT;
                  run_r[i] <= 1'b0;
                  done_r[i] <= 1'b1;
               end else begin
                  cnt_r[i] <= cnt_r[i] - CW'(1);
               end
            end
            if (op_go && (op_idx == IDX_W'(i))) begin
               case (op_code)
                  plt_pkg::plt_pulse_mode,
                  plt_pkg::plt_extended_pulse_mode,
                  plt_pkg::plt_on_delay_mode,
                  plt_pkg::plt_stored_on_delay_mode: begin
                     // time value taken on every start operation
                     init_r[i] <= load_bin;
                     rlo_r[i] <= op_rlo;
                     if (op_rlo && !rlo_r[i]) begin
                        mode_r[i] <= op_code;
                        cnt_r[i] <= load_bin;
                        base_r[i] <= load_base;
                        run_r[i] <= 1'b1;
                        done_r[i] <= 1'b0;
                        held_r[i] <= 1'b0;
                     end else if (!op_rlo &&
                                  (op_code == plt_pkg::plt_pulse_mode ||
                                   op_code == plt_pkg::plt_on_delay_mode)) begin
                        // logic bit 0 clears the timer
                        mode_r[i] <= op_code;
                        cnt_r[i] <= `PLT_RST_CNT;
                        run_r[i] <= 1'b0;
                        done_r[i] <= 1'b0;
                     end
                     // other modes ignore a 0 logic bit
                  end
                  plt_pkg::plt_off_delay_mode: begin
                     init_r[i] <= load_bin;
                     rlo_r[i] <= op_rlo;
                     mode_r[i] <= op_code;
                     if (op_rlo) begin
                        cnt_r[i] <= load_bin;
                        base_r[i] <= load_base;
                        run_r[i] <= 1'b0;
                        done_r[i] <= 1'b0;
                        held_r[i] <= 1'b0;
                     end else if (rlo_r[i]) begin
                        // falling edge starts from the loaded value
                        cnt_r[i] <= load_bin;
                        base_r[i] <= load_base;
                        run_r[i] <= 1'b1;
                        held_r[i] <= 1'b0;
                     end
                  end
                  plt_pkg::plt_reset_op: begin
                     // back to initial value while logic bit is 1
                     if (op_rlo) begin
                        cnt_r[i] <= init_r[i];
                        run_r[i] <= 1'b0;
                        done_r[i] <= 1'b0;
                        held_r[i] <= 1'b1;
                        rlo_r[i] <= 1'b0;
                     end
                     // reset with 0 leaves the timer alone
                  end
                  default: begin
                     held_r[i] <= held_r[i];
                  end
               endcase
            end
         end
      end
   end

   // Read data: plain and coded views of the selected timer
   always_comb begin
      rd_nxt = `PLT_RST_WORD;
      rd_err_nxt = 1'b0;
      case (s_axi_araddr)
         `PLT_OFF_ACCU: rd_nxt = accu_r;
         `PLT_OFF_OP: rd_nxt = op_word_r;
         `PLT_OFF_SEL: rd_nxt = 32'(sel_idx);
         `PLT_OFF_SCAN: begin
            rd_nxt[`PLT_SCAN_OUT_BIT] = scan_of(mode_r[sel_idx],
               run_r[sel_idx], done_r[sel_idx], rlo_r[sel_idx],
               held_r[sel_idx]);
            rd_nxt[`PLT_SCAN_RUN_BIT] = run_r[sel_idx];
            rd_nxt[`PLT_SCAN_DONE_BIT] = done_r[sel_idx];
         end
         `PLT_OFF_BIN: rd_nxt = 32'(cnt_r[sel_idx]);
         `PLT_OFF_BCD: begin
            rd_nxt[`PLT_TW_BCD_LSB +: `PLT_TW_BCD_W] = sel_bcd;
            rd_nxt[`PLT_TW_BASE_LSB +: `PLT_TW_BASE_W] = base_r[sel_idx];
         end
         default: rd_err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `PLT_RST_WORD;
         s_axi_rresp <= `PLT_RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_nxt;
         s_axi_rresp <= rd_err_nxt ? `PLT_RESP_SLVERR : `PLT_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : plt_timer_unit
`default_nettype wire

// ==== tb/plt_timer_unit_asserts.sv ====
// Bus-level checks of the timer bank, bound to its top module.
// Assumes one clock, mclk, and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module plt_timer_unit_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready longer than one cycle");
   a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read address ready longer than one cycle");
   a_b_after_hs: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_r_after_hs: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid)
      else $error("read response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   a_rst_quiet: assert property ($past(sys_rst)
      |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
      else $error("bus outputs active right after reset");
   a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while response pending");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_err_zero: assert property (s_axi_rvalid &&
      s_axi_rresp == `PLT_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returns data");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule : plt_timer_unit_chk

bind plt_timer_unit plt_timer_unit_chk i_chk (.mclk, .sys_rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);
`default_nettype wire

// ==== tb/plt_seq_model.sv ====
// Sequencer model: bus master that hands the bank time words and ops.
// Assumes the bank is the only slave; slow delays response acceptance.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module plt_seq_model (
   input wire logic mclk,
   output logic [`PLT_ADDR_W-1:0] s_axi_awaddr,
   output logic [2:0] s_axi_awprot,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [`PLT_ADDR_W-1:0] s_axi_araddr,
   output logic [2:0] s_axi_arprot,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   logic slow = 1'b0;

   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end

   task wr(input logic [7:0] a, input logic [31:0] dw,
      output logic [1:0] rs);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dw;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      fork
         begin
            do @(posedge mclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge mclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] dr,
      output logic [1:0] rs);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      if (slow) repeat (3) @(posedge mclk);
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_rvalid);
      dr = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : plt_seq_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the timer bank with a shortened prescaler.
// Assumes the sequencer model owns the register bus.
`timescale 1ns/100ps
`default_nettype none
`include "plt_defines.svh"

module testbench;
   localparam int TK = 20;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [`PLT_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int t0;
   // Output per mode just after start, and after expiry
   bit [4:0] out0 = 5'b10011;
   bit [4:0] out1 = 5'b01100;

   always #25 mclk = ~mclk;

   plt_timer_unit #(.TICK_CYCLES(TK)) i_dut (.*);
   plt_seq_model i_seq (.*);

   task test_done;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task chkr(input logic [31:0] got, input int lo, input int hi);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t got %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chkr

   task op(input int t, input logic [2:0] c, input logic b);
      i_seq.wr(`PLT_OFF_OP, {15'h0, b, 5'h0, c, 1'b0, 7'(t)}, r);
      chk(r, `PLT_RESP_OKAY);
   endtask : op

   task rdt(input int t, input logic [7:0] a);
      i_seq.wr(`PLT_OFF_SEL, 32'(t), r);
      i_seq.rd(a, d, r);
   endtask : rdt

   // Three BCD digits of the time word as an integer count
   function automatic int val(input logic [31:0] x);
      return x[11:8] * 100 + x[7:4] * 10 + x[3:0];
   endfunction : val

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      void'($urandom(32'h6BEEE1AF));
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rdt(0, `PLT_OFF_BIN);
      chk(d, 32'h0); // count cleared
      rdt(0, `PLT_OFF_SCAN);
      chk(d, 32'h0); // idle output low
      i_seq.rd(8'h40, d, r);
      chk(r, `PLT_RESP_SLVERR);
      chk(d, 32'h0);
      for (int m = 0; m < 5; m++) begin
         w = {16'h0, 2'($urandom), 14'h009};
         i_seq.wr(`PLT_OFF_ACCU, w, r);
         op(m, m[2:0], m == 4); // first level
         if (m == 4) begin
            rdt(m, `PLT_OFF_BIN);
            chk(d, 32'h9); // held at load
            rdt(m, `PLT_OFF_SCAN);
            chk(d[0], 1'b1); // driven bit reads 1
         end
         op(m, m[2:0], m != 4); // starting edge
         i_seq.slow = m[0];
         rdt(m, `PLT_OFF_SCAN);
         chk(d[0], out0[m]); // output while counting
         rdt(m, `PLT_OFF_BIN);
         chkr(d, val(w) - 2, val(w)); // top bits ignored
         repeat (TK * 11) @(posedge mclk);
         rdt(m, `PLT_OFF_SCAN);
         chk(d[0], out1[m]); // output after expiry
         rdt(m, `PLT_OFF_BIN);
         chk(d, 32'h0); // stops at zero
      end
      op(3, plt_pkg::plt_reset_op, 1'b1);
      rdt(3, `PLT_OFF_SCAN);
      chk(d[0], 1'b0); // cleared by reset
      rdt(3, `PLT_OFF_BIN);
      chk(d, 32'h9); // back to initial
      op(5, plt_pkg::plt_pulse_mode, 1'b1);
      op(5, plt_pkg::plt_pulse_mode, 1'b0);
      rdt(5, `PLT_OFF_BIN);
      chk(d, 32'h0); // low bit clears
      op(6, plt_pkg::plt_extended_pulse_mode, 1'b1);
      repeat (TK * 4) @(posedge mclk);
      op(6, plt_pkg::plt_extended_pulse_mode, 1'b0);
      rdt(6, `PLT_OFF_SCAN);
      chk(d[0], 1'b1); // low bit ignored
      op(6, plt_pkg::plt_extended_pulse_mode, 1'b1);
      rdt(6, `PLT_OFF_BIN);
      chkr(d, 7, 9); // reload on edge
      i_seq.wr(`PLT_OFF_ACCU, 32'h0000_2123, r);
      op(7, plt_pkg::plt_pulse_mode, 1'b1); // word taken
      rdt(7, `PLT_OFF_BCD);
      chkr(d, 32'h2122, 32'h2123); // coded read
      rdt(7, `PLT_OFF_BIN);
      chkr(d, 122, 123); // digit decode
      i_seq.wr(`PLT_OFF_ACCU, 32'h0000_0002, r);
      op(8, plt_pkg::plt_pulse_mode, 1'b1);
      t0 = cyc;
      do rdt(8, `PLT_OFF_SCAN); while (d[0] !== 1'b0);
      chkr(cyc - t0, TK - 2, 2 * TK + 16); // within one unit
      // Base 1 with two counts must outlive a base-0 timer by far
      i_seq.wr(`PLT_OFF_ACCU, 32'h0000_1002, r);
      op(9, plt_pkg::plt_pulse_mode, 1'b1);
      repeat (TK * 5) @(posedge mclk);
      rdt(9, `PLT_OFF_SCAN);
      chk(d[0], 1'b1); // base 1 still running
      repeat (TK * 20) @(posedge mclk);
      rdt(9, `PLT_OFF_SCAN);
      chk(d[0], 1'b0); // base 1 expired
      test_done();
   end
endmodule : testbench
`default_nettype wire
